// ---- design/energy_meter_result_config_regs.sv ----
/*
 * Paged result and configuration registers of the energy meter: power
 * ratio, apparent, harmonic and fundamental powers, control word, page
 * select, temperature scaling and sag/fault durations. Assumes the serial
 * command engine presents one-cycle read and write strobes with a 5-bit
 * address, and that the computation engine pulses result_strobe with
 * fresh measured values once per computation cycle.
 */
`timescale 1ns/1ns

// Functional notes
// (RL1) power ratio is active over apparent, signed
// (RL2) apparent power is rms voltage times current
// (RL3) control bit 8 aborts boot, reset zero
// (RL4) control bit 4 makes interrupt pin open drain
// (RL5) control bit 2 stops host clock pin
// (RL6) control bit 1 stops crystal oscillator
// (RL7) harmonic power is active minus fundamental
// (RL8) fundamental active power from DFT products
// (RL9) address 31 read gives fundamental reactive power
// (RL10) address 31 write loads 7-bit page select
// (RL11) temperature gain resets to 34E2E7
// (RL12) temperature offset resets to F3E7D0
// (RL13) sag and fault durations reset to zero
// (RL14) zero duration disables sag or fault detection
// (RL15) undefined control bits read zero, ignored
module energy_meter_result_config_regs #(
	parameter int DATA_W = 24
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [meter_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	input wire meter_pkg::meas_t meas,
	input wire logic result_strobe,
	output logic result_busy,
	input wire logic irq_req,
	output logic irq_pin_o,
	output logic irq_pin_oe,
	output logic host_clock_output_pin,
	output meter_pkg::cfg_t cfg
);
	generate
		if (DATA_W != meter_pkg::DATA_W) begin : g_bad_width
			$error("register word must be 24 bits wide");
		end
	endgenerate

	// register file state
	logic [DATA_W-1:0] control_q, control_d, temperature_scale_gain_q, temperature_scale_gain_d, temperature_zero_offset_q, temperature_zero_offset_d;
	logic [DATA_W-1:0] vsag_q, vsag_d, ifault_q, ifault_d, rdata_q, rdata_d;
	logic [meter_pkg::PAGE_W-1:0] page_q, page_d, wr_page;
	logic rvalid_q, rvalid_d, sag_en_q, sag_en_d, fault_en_q, fault_en_d;
	// result state
	meter_pkg::ratio_state_t st_q, st_d;
	logic [DATA_W-1:0] ratio_q, ratio_d, apparent_q, apparent_d, harm_q, harm_d;
	logic [DATA_W-1:0] fund_p_q, fund_p_d, fund_q_q, fund_q_d, active_q, active_d;
	// pin state
	logic irq_o_q, irq_o_d, irq_oe_q, irq_oe_d, hclk_q, hclk_d;
	// arithmetic
	logic [2*DATA_W-1:0] prod_rms;
	logic signed [2*DATA_W-1:0] m_re, m_im, m_x1, m_x2;
	logic signed [2*DATA_W:0] sum_p, diff_q;
	logic [DATA_W-1:0] mag;
	logic accept, div_start, div_done;
	logic [meter_pkg::FRAC_W-1:0] div_quot;

	assign wr_page = reg_wdata[meter_pkg::PAGE_W-1:0];

	// products behind the fundamental and apparent values
	assign prod_rms = meas.v_rms * meas.i_rms;
	assign m_re = $signed(meas.v_re) * $signed(meas.i_re);
	assign m_im = $signed(meas.v_im) * $signed(meas.i_im);
	assign m_x1 = $signed(meas.v_im) * $signed(meas.i_re);
	assign m_x2 = $signed(meas.v_re) * $signed(meas.i_im);
	assign sum_p = (2*DATA_W+1)'(m_re) + (2*DATA_W+1)'(m_im);
	assign diff_q = (2*DATA_W+1)'(m_x1) - (2*DATA_W+1)'(m_x2);
	assign mag = active_q[DATA_W-1] ? DATA_W'(-active_q) : active_q;
	assign accept = result_strobe && (st_q == meter_pkg::ST_IDLE);

	// register writes and read data
	always_comb begin
		control_d = control_q;
		page_d = page_q;
		temperature_scale_gain_d = temperature_scale_gain_q;
		temperature_zero_offset_d = temperature_zero_offset_q;
		vsag_d = vsag_q;
		ifault_d = ifault_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		if (reg_wr) begin
			// (RL10) page select load
			if (reg_addr == meter_pkg::ADDR_PAGE_SELECT) begin
				page_d = wr_page;
			end else begin
				case (page_q)
					meter_pkg::PAGE_RESULTS: begin
						// (RL15) undefined bits masked
						if (reg_addr == meter_pkg::ADDR_CONTROL) begin
							control_d = reg_wdata & meter_pkg::CONTROL_MASK;
						end
					end
					meter_pkg::PAGE_TEMP: begin
						if (reg_addr == meter_pkg::ADDR_TEMP_GAIN) begin
							temperature_scale_gain_d = reg_wdata;
						end else if (reg_addr == meter_pkg::ADDR_TEMP_OFFSET) begin
							temperature_zero_offset_d = reg_wdata;
						end
					end
					meter_pkg::PAGE_SAG: begin
						if (reg_addr == meter_pkg::ADDR_VSAG_DUR) begin
							vsag_d = reg_wdata;
						end else if (reg_addr == meter_pkg::ADDR_IFAULT_DUR) begin
							ifault_d = reg_wdata;
						end
					end
					default: begin
					end
				endcase
			end
		end
		if (reg_rd) begin
			rvalid_d = 1'b1;
			rdata_d = '0;
			case (page_q)
				meter_pkg::PAGE_RESULTS: begin
					case (reg_addr)
						meter_pkg::ADDR_POWER_FACTOR: rdata_d = ratio_q;
						meter_pkg::ADDR_APPARENT: rdata_d = apparent_q;
						meter_pkg::ADDR_CONTROL: rdata_d = control_q;
						meter_pkg::ADDR_HARMONIC: rdata_d = harm_q;
						meter_pkg::ADDR_FUND_ACTIVE: rdata_d = fund_p_q;
						// (RL9) reactive read side
						meter_pkg::ADDR_FUND_REACTIVE: rdata_d = fund_q_q;
						default: rdata_d = '0;
					endcase
				end
				meter_pkg::PAGE_TEMP: begin
					if (reg_addr == meter_pkg::ADDR_TEMP_GAIN) begin
						rdata_d = temperature_scale_gain_q;
					end else if (reg_addr == meter_pkg::ADDR_TEMP_OFFSET) begin
						rdata_d = temperature_zero_offset_q;
					end
				end
				meter_pkg::PAGE_SAG: begin
					if (reg_addr == meter_pkg::ADDR_VSAG_DUR) begin
						rdata_d = vsag_q;
					end else if (reg_addr == meter_pkg::ADDR_IFAULT_DUR) begin
						rdata_d = ifault_q;
					end
				end
				default: rdata_d = '0;
			endcase
		end
		// (RL14) zero duration disables
		sag_en_d = (vsag_d != '0);
		fault_en_d = (ifault_d != '0);
	end

	// (RL3) (RL11) (RL12) (RL13) reset values
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			control_q <= meter_pkg::CONTROL_RST;
			page_q <= meter_pkg::PAGE_RST;
			temperature_scale_gain_q <= meter_pkg::TEMP_GAIN_RST;
			temperature_zero_offset_q <= meter_pkg::TEMP_OFFSET_RST;
			vsag_q <= meter_pkg::DURATION_RST;
			ifault_q <= meter_pkg::DURATION_RST;
			rdata_q <= '0;
			rvalid_q <= 1'b0;
			sag_en_q <= 1'b0;
			fault_en_q <= 1'b0;
		end else begin
			control_q <= control_d;
			page_q <= page_d;
			temperature_scale_gain_q <= temperature_scale_gain_d;
			temperature_zero_offset_q <= temperature_zero_offset_d;
			vsag_q <= vsag_d;
			ifault_q <= ifault_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			sag_en_q <= sag_en_d;
			fault_en_q <= fault_en_d;
		end
	end

	// result capture and power ratio sequencing
	always_comb begin
		st_d = st_q;
		ratio_d = ratio_q;
		apparent_d = apparent_q;
		harm_d = harm_q;
		fund_p_d = fund_p_q;
		fund_q_d = fund_q_q;
		active_d = active_q;
		div_start = 1'b0;
		case (st_q)
			meter_pkg::ST_IDLE: begin
				if (result_strobe) begin
					// (RL2) apparent from rms product
					apparent_d = {1'b0, prod_rms[2*DATA_W-3:meter_pkg::FRAC_W]};
					// (RL8) fundamental active power
					fund_p_d = sum_p[2*DATA_W-2:meter_pkg::FRAC_W];
					// (RL9) fundamental reactive power
					fund_q_d = diff_q[2*DATA_W-2:meter_pkg::FRAC_W];
					// (RL7) harmonic as difference
					harm_d = meas.active - sum_p[2*DATA_W-2:meter_pkg::FRAC_W];
					active_d = meas.active;
					st_d = meter_pkg::ST_LOAD;
				end
			end
			meter_pkg::ST_LOAD: begin
				// (RL1) screen zero and full-scale ratios
				if (apparent_q == '0) begin
					ratio_d = '0;
					st_d = meter_pkg::ST_IDLE;
				end else if (mag >= apparent_q) begin
					ratio_d = active_q[DATA_W-1] ? meter_pkg::RATIO_MIN : meter_pkg::RATIO_MAX;
					st_d = meter_pkg::ST_IDLE;
				end else begin
					div_start = 1'b1;
					st_d = meter_pkg::ST_RUN;
				end
			end
			meter_pkg::ST_RUN: begin
				// (RL1) signed quotient
				if (div_done) begin
					ratio_d = active_q[DATA_W-1] ? DATA_W'(-{1'b0, div_quot}) : {1'b0, div_quot};
					st_d = meter_pkg::ST_IDLE;
				end
			end
			default: st_d = meter_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q <= meter_pkg::ST_IDLE;
			ratio_q <= '0;
			apparent_q <= '0;
			harm_q <= '0;
			fund_p_q <= '0;
			fund_q_q <= '0;
			active_q <= '0;
		end else begin
			st_q <= st_d;
			ratio_q <= ratio_d;
			apparent_q <= apparent_d;
			harm_q <= harm_d;
			fund_p_q <= fund_p_d;
			fund_q_q <= fund_q_d;
			active_q <= active_d;
		end
	end

	ratio_divider #(
		.W(meter_pkg::FRAC_W)
	) u_div (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.start(div_start),
		.num(mag[meter_pkg::FRAC_W-1:0]),
		.den(apparent_q[meter_pkg::FRAC_W-1:0]),
		.busy(),
		.done(div_done),
		.quot(div_quot)
	);

	// interrupt and host clock pins
	always_comb begin
		// (RL4) open drain or push-pull
		irq_o_d = control_q[meter_pkg::BIT_IRQ_OPEN_DRAIN] ? 1'b0 : ~irq_req;
		irq_oe_d = control_q[meter_pkg::BIT_IRQ_OPEN_DRAIN] ? irq_req : 1'b1;
		// (RL5) host clock held low
		hclk_d = control_q[meter_pkg::BIT_HOST_CLK_OFF] ? 1'b0 : ~hclk_q;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_o_q <= 1'b1;
			irq_oe_q <= 1'b1;
			hclk_q <= 1'b0;
		end else begin
			irq_o_q <= irq_o_d;
			irq_oe_q <= irq_oe_d;
			hclk_q <= hclk_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign result_busy = (st_q != meter_pkg::ST_IDLE);
	assign irq_pin_o = irq_o_q;
	assign irq_pin_oe = irq_oe_q;
	assign host_clock_output_pin = hclk_q;
	// (RL3) (RL6) control levels out
	assign cfg.boot_abort = control_q[meter_pkg::BIT_BOOT_ABORT];
	assign cfg.crystal_osc_off = control_q[meter_pkg::BIT_OSC_OFF];
	assign cfg.host_clock_out_off = control_q[meter_pkg::BIT_HOST_CLK_OFF];
	assign cfg.irq_pin_open_drain = control_q[meter_pkg::BIT_IRQ_OPEN_DRAIN];
	assign cfg.sag_detect_en = sag_en_q;
	assign cfg.fault_detect_en = fault_en_q;
	assign cfg.page_select = page_q;
	assign cfg.temperature_scale_gain = temperature_scale_gain_q;
	assign cfg.temperature_zero_offset = temperature_zero_offset_q;
	assign cfg.voltage_sag_duration = vsag_q;
	assign cfg.current_fault_duration = ifault_q;

	// checks on the design's own behaviour
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	logic ctrl_wr;
	assign ctrl_wr = reg_wr && page_q == meter_pkg::PAGE_RESULTS
		&& reg_addr == meter_pkg::ADDR_CONTROL;

	a_reset_values: assert property ($fell(sys_rst) |-> control_q == '0 && page_q == '0 // (RL3)
		&& temperature_scale_gain_q == meter_pkg::TEMP_GAIN_RST && temperature_zero_offset_q == meter_pkg::TEMP_OFFSET_RST
		&& vsag_q == '0 && ifault_q == '0) else $error("reset values wrong");
	a_ratio_sign: assert property (st_q == meter_pkg::ST_RUN && div_done |=> // (RL1)
		ratio_q == '0 || ratio_q[DATA_W-1] == active_q[DATA_W-1]) else $error("ratio sign wrong");
	a_ratio_latency: assert property (accept |-> ##[2:28] st_q == meter_pkg::ST_IDLE) // (RL1)
		else $error("ratio not finished in time");
	a_apparent_msb: assert property (apparent_q[DATA_W-1] == 1'b0) // (RL2)
		else $error("apparent msb set");
	a_boot_abort: assert property (ctrl_wr && reg_wdata[meter_pkg::BIT_BOOT_ABORT] // (RL3)
		|=> cfg.boot_abort) else $error("boot abort not set");
	a_od_pin: assert property (control_q[meter_pkg::BIT_IRQ_OPEN_DRAIN] |=> // (RL4)
		irq_pin_oe == $past(irq_req) && !irq_pin_o) else $error("open drain pin wrong");
	a_host_clk_off: assert property (control_q[meter_pkg::BIT_HOST_CLK_OFF] [*2] // (RL5)
		|-> !host_clock_output_pin) else $error("host clock still running");
	a_osc_off: assert property (ctrl_wr && reg_wdata[meter_pkg::BIT_OSC_OFF] // (RL6)
		|=> cfg.crystal_osc_off) else $error("oscillator not stopped");
	a_harm_diff: assert property (accept |=> harm_q == DATA_W'(active_q - fund_p_q)) // (RL7)
		else $error("harmonic not difference");
	a_reactive_read: assert property (reg_rd && page_q == '0 // (RL9)
		&& reg_addr == meter_pkg::ADDR_FUND_REACTIVE |=> reg_rvalid && reg_rdata == $past(fund_q_q))
		else $error("reactive read wrong");
	a_page_write: assert property (reg_wr && reg_addr == meter_pkg::ADDR_PAGE_SELECT // (RL10)
		|=> page_q == $past(wr_page)) else $error("page not loaded");
	a_sag_disable: assert property (reg_wr && page_q == meter_pkg::PAGE_SAG // (RL14)
		&& reg_addr == meter_pkg::ADDR_VSAG_DUR && reg_wdata == '0 |=> !cfg.sag_detect_en)
		else $error("sag detect not disabled");
	a_reserved_zero: assert property ((control_q & ~meter_pkg::CONTROL_MASK) == '0) // (RL15)
		else $error("undefined control bit set");

	c_ratio_divided: cover property (st_q == meter_pkg::ST_RUN && div_done);
	c_page_then_temp: cover property (reg_wr && reg_addr == meter_pkg::ADDR_PAGE_SELECT
		##[1:5] reg_rd && page_q == meter_pkg::PAGE_TEMP);
	c_open_drain_irq: cover property (control_q[meter_pkg::BIT_IRQ_OPEN_DRAIN] && irq_req);

endmodule : energy_meter_result_config_regs

// ---- design/meter_pkg.sv ----
/*
 * Shared constants and carrier types for the energy meter result and
 * configuration register bank. Assumes a 24-bit register word and a
 * 7-bit page-select value, as the serial command engine presents them.
 */
package meter_pkg;

	// word layout
	localparam int DATA_W = 24;
	localparam int ADDR_W = 5;
	localparam int PAGE_W = 7;
	localparam int FRAC_W = 23;

	// page numbers
	localparam logic [PAGE_W-1:0] PAGE_RESULTS = 7'h00;
	localparam logic [PAGE_W-1:0] PAGE_TEMP = 7'h01;
	localparam logic [PAGE_W-1:0] PAGE_SAG = 7'h03;

	// page 0 addresses
	localparam logic [ADDR_W-1:0] ADDR_POWER_FACTOR = 5'h19;
	localparam logic [ADDR_W-1:0] ADDR_APPARENT = 5'h1B;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 5'h1C;
	localparam logic [ADDR_W-1:0] ADDR_HARMONIC = 5'h1D;
	localparam logic [ADDR_W-1:0] ADDR_FUND_ACTIVE = 5'h1E;
	localparam logic [ADDR_W-1:0] ADDR_FUND_REACTIVE = 5'h1F;
	localparam logic [ADDR_W-1:0] ADDR_PAGE_SELECT = 5'h1F;
	// page 1 and page 3 addresses
	localparam logic [ADDR_W-1:0] ADDR_TEMP_GAIN = 5'h02;
	localparam logic [ADDR_W-1:0] ADDR_TEMP_OFFSET = 5'h03;
	localparam logic [ADDR_W-1:0] ADDR_VSAG_DUR = 5'h06;
	localparam logic [ADDR_W-1:0] ADDR_IFAULT_DUR = 5'h0A;

	// control word bit positions
	localparam int BIT_BOOT_ABORT = 8;
	localparam int BIT_IRQ_OPEN_DRAIN = 4;
	localparam int BIT_HOST_CLK_OFF = 2;
	localparam int BIT_OSC_OFF = 1;
	localparam logic [DATA_W-1:0] CONTROL_MASK = 24'h000116;

	// reset values
	localparam logic [DATA_W-1:0] CONTROL_RST = 24'h000000;
	localparam logic [PAGE_W-1:0] PAGE_RST = 7'h00;
	localparam logic [DATA_W-1:0] TEMP_GAIN_RST = 24'h34E2E7;
	localparam logic [DATA_W-1:0] TEMP_OFFSET_RST = 24'hF3E7D0;
	localparam logic [DATA_W-1:0] DURATION_RST = 24'h000000;

	// saturated ratio values
	localparam logic [DATA_W-1:0] RATIO_MAX = 24'h7FFFFF;
	localparam logic [DATA_W-1:0] RATIO_MIN = 24'h800000;

	// measured values handed over by the computation engine
	typedef struct packed {
		logic [DATA_W-1:0] active;
		logic [DATA_W-1:0] v_rms;
		logic [DATA_W-1:0] i_rms;
		logic [DATA_W-1:0] v_re;
		logic [DATA_W-1:0] v_im;
		logic [DATA_W-1:0] i_re;
		logic [DATA_W-1:0] i_im;
	} meas_t;

	// configuration levels handed to the rest of the device
	typedef struct packed {
		logic boot_abort;
		logic crystal_osc_off;
		logic host_clock_out_off;
		logic irq_pin_open_drain;
		logic sag_detect_en;
		logic fault_detect_en;
		logic [PAGE_W-1:0] page_select;
		logic [DATA_W-1:0] temperature_scale_gain;
		logic [DATA_W-1:0] temperature_zero_offset;
		logic [DATA_W-1:0] voltage_sag_duration;
		logic [DATA_W-1:0] current_fault_duration;
	} cfg_t;

	// ratio sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_LOAD = 3'b010,
		ST_RUN = 3'b100
	} ratio_state_t;

endpackage : meter_pkg

// ---- design/ratio_divider.sv ----
/*
 * Restoring divider for unsigned fractions: quotient = num / den in units
 * of 2^-W. Assumes num < den and den non-zero; the caller screens both.
 */
`timescale 1ns/1ns
module ratio_divider #(
	parameter int W = 23
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	output logic busy,
	output logic done,
	output logic [W-1:0] quot
);
	localparam int CW = $clog2(W + 1);

	generate
		if (W < 2) begin : g_bad_width
			$error("ratio_divider needs W of at least 2");
		end
	endgenerate

	logic [W:0] rem_q, rem_d;
	logic [W-1:0] den_q, den_d, quot_q, quot_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic busy_q, busy_d, done_q, done_d;
	logic [W+1:0] shifted;

	// one quotient bit per cycle
	always_comb begin
		rem_d = rem_q;
		den_d = den_q;
		quot_d = quot_q;
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		shifted = {rem_q, 1'b0};
		if (start && !busy_q) begin
			rem_d = {1'b0, num};
			den_d = den;
			cnt_d = CW'(W);
			busy_d = 1'b1;
		end else if (busy_q) begin
			if (shifted >= {2'b00, den_q}) begin
				rem_d = (W+1)'(shifted - {2'b00, den_q});
				quot_d = {quot_q[W-2:0], 1'b1};
			end else begin
				rem_d = shifted[W:0];
				quot_d = {quot_q[W-2:0], 1'b0};
			end
			cnt_d = cnt_q - 1'b1;
			if (cnt_q == CW'(1)) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rem_q <= '0;
			den_q <= '0;
			quot_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			rem_q <= rem_d;
			den_q <= den_d;
			quot_q <= quot_d;
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign busy = busy_q;
	assign done = done_q;
	assign quot = quot_q;

endmodule : ratio_divider

// ---- verif/host_port_model.sv ----
/*
 * Host side of the register strobe port: issues one-cycle write and read
 * strobes and collects the read answer. Assumes the bank answers a read
 * at the same edge that took it.
 */
`timescale 1ns/1ns
module host_port_model (
	input wire logic clk_sys,
	input wire logic [23:0] reg_rdata,
	input wire logic reg_rvalid,
	output logic reg_wr,
	output logic reg_rd,
	output logic [meter_pkg::ADDR_W-1:0] reg_addr,
	output logic [23:0] reg_wdata
);
	// extra idle cycles before each request; zero still leaves one idle cycle between requests
	int gap = 0;

	// quiet strobes at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
	end

	// released lines show the inverse so stale values never look valid
	task automatic put(input logic [4:0] a, input logic [23:0] d);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		#10;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk_sys);
		#10;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : put

	// answer is taken in the cycle after the strobe edge
	task automatic get(input logic [4:0] a, output logic [23:0] d, output logic v);
		repeat (gap) @(posedge clk_sys);
		@(posedge clk_sys);
		#10;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk_sys);
		#10;
		reg_rd = 1'b0;
		reg_addr = ~a;
		v = reg_rvalid;
		d = reg_rdata;
	endtask : get

	task automatic set_page(input logic [6:0] p);
		put(meter_pkg::ADDR_PAGE_SELECT, {17'h00000, p});
	endtask : set_page
endmodule : host_port_model

// ---- verif/testbench.sv ----
/*
 * Self-checking bench for the result and configuration register bank.
 * Assumes the host model drives the strobe port and this module drives
 * measured values, result strobes and the interrupt request.
 */
`timescale 1ns/1ns
module testbench;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr, reg_rd, reg_rvalid, result_strobe, result_busy, irq_req;
	logic irq_pin_o, irq_pin_oe, host_clock_output_pin, rd_ok, a;
	logic [4:0] reg_addr;
	logic [23:0] reg_wdata, reg_rdata, rd_val;
	meter_pkg::meas_t meas;
	meter_pkg::cfg_t cfg;
	int errors = 0;
	int check_count = 0;

	// 10 MHz system clock
	always #50 clk_sys = ~clk_sys;

	host_port_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

	energy_meter_result_config_regs #(.DATA_W(24)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .meas(meas),
		.result_strobe(result_strobe), .result_busy(result_busy), .irq_req(irq_req),
		.irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
		.host_clock_output_pin(host_clock_output_pin), .cfg(cfg));

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// read with answer pulse and value compared
	task automatic rchk(input logic [4:0] ad, input logic [23:0] exp, input string what);
		host.get(ad, rd_val, rd_ok);
		chk({23'h0, rd_ok}, 24'h000001, what);
		chk(rd_val, exp, what);
	endtask : rchk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#10;
	endtask : tick

	// one result strobe, taken at the next edge
	task automatic strobe(input meter_pkg::meas_t m);
		@(posedge clk_sys);
		#10;
		meas = m;
		result_strobe = 1'b1;
		@(posedge clk_sys);
		#10;
		result_strobe = 1'b0;
	endtask : strobe

	// bounded wait for the ratio sequencer to go idle
	task automatic wait_idle();
		int n;
		n = 0;
		while (result_busy !== 1'b0 && n < 100) begin
			tick(1);
			n++;
		end
		chk({23'h0, result_busy}, 24'h000000, "busy stuck");
	endtask : wait_idle

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out

	// watchdog well beyond the expected few hundred cycles
	initial begin
		#(3000 * 100);
		errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		close_out();
	end

	initial begin
		meas = '0;
		result_strobe = 1'b0;
		irq_req = 1'b0;
		tick(6);
		sys_rst = 1'b0;
		// paged configuration registers
		rchk(meter_pkg::ADDR_CONTROL, 24'h000000, "ctrl reset");
		host.set_page(7'h01);
		chk({17'h0, cfg.page_select}, 24'h000001, "page select");
		rchk(meter_pkg::ADDR_TEMP_GAIN, 24'h34E2E7, "gain reset");
		rchk(meter_pkg::ADDR_TEMP_OFFSET, 24'hF3E7D0, "offset reset");
		rchk(5'h1F, 24'h000000, "reactive off page");
		host.put(meter_pkg::ADDR_TEMP_GAIN, 24'h123456);
		rchk(meter_pkg::ADDR_TEMP_GAIN, 24'h123456, "gain rw");
		chk(cfg.temperature_scale_gain, 24'h123456, "gain level");
		host.set_page(7'h02);
		rchk(meter_pkg::ADDR_TEMP_GAIN, 24'h000000, "empty page");
		host.set_page(7'h03);
		chk({22'h0, cfg.sag_detect_en, cfg.fault_detect_en}, 24'h0, "enables off");
		rchk(meter_pkg::ADDR_VSAG_DUR, 24'h000000, "sag dur reset");
		rchk(meter_pkg::ADDR_IFAULT_DUR, 24'h000000, "fault dur reset");
		host.put(meter_pkg::ADDR_VSAG_DUR, 24'h000005);
		tick(1);
		chk({22'h0, cfg.sag_detect_en, cfg.fault_detect_en}, 24'h2, "sag on");
		host.gap = 2;
		host.put(meter_pkg::ADDR_VSAG_DUR, 24'h000000);
		host.put(meter_pkg::ADDR_IFAULT_DUR, 24'h800000);
		host.gap = 0;
		tick(1);
		chk({22'h0, cfg.sag_detect_en, cfg.fault_detect_en}, 24'h1, "fault on");
		rchk(meter_pkg::ADDR_IFAULT_DUR, 24'h800000, "fault dur rw");
		chk(cfg.current_fault_duration, 24'h800000, "fault level");
		chk(cfg.voltage_sag_duration, 24'h000000, "sag level");
		$display("test paged registers done");

		// control word and pins
		host.set_page(7'h00);
		a = host_clock_output_pin;
		tick(1);
		chk({23'h0, host_clock_output_pin}, {23'h0, ~a}, "clock runs");
		host.put(meter_pkg::ADDR_CONTROL, 24'hFFFFFF);
		rchk(meter_pkg::ADDR_CONTROL, 24'h000116, "ctrl mask");
		chk({20'h0, cfg.boot_abort, cfg.crystal_osc_off, cfg.host_clock_out_off,
			cfg.irq_pin_open_drain}, 24'hF, "ctrl levels");
		tick(1);
		repeat (4) begin
			chk({23'h0, host_clock_output_pin}, 24'h0, "clock stopped");
			tick(1);
		end
		irq_req = 1'b1;
		tick(2);
		chk({22'h0, irq_pin_o, irq_pin_oe}, 24'h1, "od asserted");
		irq_req = 1'b0;
		tick(2);
		chk({22'h0, irq_pin_o, irq_pin_oe}, 24'h0, "od released");
		host.put(meter_pkg::ADDR_CONTROL, 24'h000100);
		irq_req = 1'b1;
		tick(2);
		chk({22'h0, irq_pin_o, irq_pin_oe}, 24'h1, "push low");
		irq_req = 1'b0;
		tick(2);
		chk({22'h0, irq_pin_o, irq_pin_oe}, 24'h3, "push high");
		// clock must run again once bit 2 is cleared
		a = host_clock_output_pin;
		tick(1);
		chk({23'h0, host_clock_output_pin}, {23'h0, ~a}, "clock restarts");
		chk({20'h0, cfg.boot_abort, cfg.crystal_osc_off, cfg.host_clock_out_off,
			cfg.irq_pin_open_drain}, 24'h8, "abort only");
		$display("test control done");

		// results, a busy strobe dropped, then a saturated ratio
		strobe('{24'h100000, 24'h400000, 24'h400000, 24'h400000, 24'h200000, 24'h200000,
			24'h200000});
		strobe('{24'h300000, 24'h100000, 24'h100000, 24'h100000, 24'h100000, 24'h100000,
			24'h100000});
		wait_idle();
		rchk(meter_pkg::ADDR_APPARENT, 24'h200000, "apparent");
		rchk(meter_pkg::ADDR_POWER_FACTOR, 24'h400000, "ratio");
		rchk(meter_pkg::ADDR_FUND_ACTIVE, 24'h180000, "fund active");
		rchk(meter_pkg::ADDR_FUND_REACTIVE, 24'hF80000, "fund reactive");
		rchk(meter_pkg::ADDR_HARMONIC, 24'hF80000, "harmonic");
		strobe('{24'hC00000, 24'h400000, 24'h400000, 24'h400000, 24'h200000, 24'h200000,
			24'h200000});
		wait_idle();
		rchk(meter_pkg::ADDR_POWER_FACTOR, 24'h800000, "ratio floor");
		rchk(meter_pkg::ADDR_HARMONIC, 24'hA80000, "harmonic neg");
		rchk(5'h00, 24'h000000, "unmapped");
		// negative quotient, positive ceiling and zero apparent power
		strobe('{24'hF00000, 24'h400000, 24'h400000, 24'h400000, 24'h200000, 24'h200000,
			24'h200000});
		wait_idle();
		rchk(meter_pkg::ADDR_POWER_FACTOR, 24'hC00000, "ratio negative");
		strobe('{24'h200000, 24'h400000, 24'h400000, 24'h400000, 24'h200000, 24'h200000,
			24'h200000});
		wait_idle();
		rchk(meter_pkg::ADDR_POWER_FACTOR, 24'h7FFFFF, "ratio ceiling");
		strobe('{24'h100000, 24'h000000, 24'h400000, 24'h400000, 24'h200000, 24'h200000,
			24'h200000});
		wait_idle();
		rchk(meter_pkg::ADDR_APPARENT, 24'h000000, "apparent zero");
		rchk(meter_pkg::ADDR_POWER_FACTOR, 24'h000000, "ratio zero");
		// reset in mid-run restores written registers and the page
		sys_rst = 1'b1;
		tick(2);
		sys_rst = 1'b0;
		rchk(meter_pkg::ADDR_CONTROL, 24'h000000, "ctrl after reset");
		host.set_page(7'h01);
		rchk(meter_pkg::ADDR_TEMP_GAIN, 24'h34E2E7, "gain after reset");
		chk(cfg.temperature_zero_offset, 24'hF3E7D0, "offset level");
		$display("test results done");
		close_out();
	end
endmodule : testbench
